// ==== core/bct_channel.sv ====
// one counter channel: byte access, latching, counting profiles
`timescale 1ns/10ps
module bct_channel (
	input  wire logic       mclk_in,      // system clock
	input  wire logic       rst_in,       // synchronous reset
	input  wire logic       ctl_wr_in,    // control word for this channel
	input  wire logic [5:0] ctl_in,       // control word bits 5:0
	input  wire logic       rb_count_in,  // read-back count latch
	input  wire logic       rb_status_in, // read-back status latch
	input  wire logic       wr_in,        // data byte write
	input  wire logic       rd_in,        // data byte read
	input  wire logic [7:0] wdata_in,     // written byte
	output logic      [7:0] rdata_out,    // byte that a read returns
	input  wire logic       tick_in,      // counting clock enable
	input  wire logic       gate_in,      // gate level
	output logic            out_out       // counter output
);
	logic [2:0]  mode;
	logic [1:0]  rwm;
	logic        bcd;
	logic [15:0] cr, count, ol;
	logic [7:0]  status, wlo;
	logic        latched, st_latched, wtog, rtog, null_cnt;
	logic        load_pend, trig, gate_q, armed;
	logic [15:0] src;
	bct_pkg::bct_profile_type prof;

	// one step down, binary or four decimal decades
	function automatic logic [15:0] dec(input logic [15:0] v, input logic b);
		logic [15:0] r;
		logic        brw;
		r   = v;
		brw = 1'b1;
		if (!b)
			r = v - 16'h0001;
		else
			for (int k = 0; k < 4; k++) begin
				if (brw) begin
					if (r[k*4 +: 4] == 4'h0)
						r[k*4 +: 4] = 4'h9;
					else begin
						r[k*4 +: 4] = r[k*4 +: 4] - 4'h1;
						brw = 1'b0;
					end
				end
			end
		return r;
	endfunction

	assign prof = bct_pkg::profile(mode);

	//****************************************************
	// read data selection
	//****************************************************
	assign src = latched ? ol : count;
	always_comb begin
		if (st_latched)
			rdata_out = status;
		else if (rwm == bct_pkg::RW_MSB || (rwm == bct_pkg::RW_BOTH && rtog))
			rdata_out = src[15:8];
		else
			rdata_out = src[7:0];
	end

	//****************************************************
	// channel core
	//****************************************************
	// host access and counting share state, so one process keeps order clear
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			mode <= 3'h0; rwm <= bct_pkg::RW_BOTH; bcd <= 1'b0;
			cr <= 16'h0000; count <= 16'h0000; ol <= 16'h0000;
			status <= 8'h00; wlo <= 8'h00; latched <= 1'b0;
			st_latched <= 1'b0; wtog <= 1'b0; rtog <= 1'b0;
			null_cnt <= 1'b1; load_pend <= 1'b0; trig <= 1'b0;
			gate_q <= 1'b1; armed <= 1'b0; out_out <= 1'b0;
		end else begin
			gate_q <= gate_in;
			// counting, on the slow enable only
			if (tick_in) begin
				if (load_pend && (!(prof == bct_pkg::BCT_ONESHOT
						|| prof == bct_pkg::BCT_HWSTROBE) || trig)) begin
					count <= cr; load_pend <= 1'b0; null_cnt <= 1'b0;
					trig <= 1'b0; armed <= 1'b1;
					if (prof == bct_pkg::BCT_ONESHOT)
						out_out <= 1'b0;
				end else if (!load_pend && trig && (prof ==
						bct_pkg::BCT_ONESHOT || prof == bct_pkg::BCT_HWSTROBE)) begin
					count <= cr; trig <= 1'b0; armed <= 1'b1;
					if (prof == bct_pkg::BCT_ONESHOT)
						out_out <= 1'b0;
				end else if (!load_pend && (gate_in || prof ==
						bct_pkg::BCT_ONESHOT || prof == bct_pkg::BCT_HWSTROBE)) begin
					case (prof)
					bct_pkg::BCT_TERM, bct_pkg::BCT_ONESHOT: begin
						count <= dec(count, bcd);
						if (count == 16'h0001 && armed)
							out_out <= 1'b1;
					end
					bct_pkg::BCT_RATE: begin
						if (count == 16'h0001) begin
							count <= cr; out_out <= 1'b1;
						end else begin
							count <= dec(count, bcd);
							out_out <= (count != 16'h0002);
						end
					end
					bct_pkg::BCT_SQUARE: begin
						// halves toggle; odd reload values run one step long
						if (count <= 16'h0002) begin
							count <= cr; out_out <= !out_out;
						end else
							count <= dec(dec(count, bcd), bcd);
					end
					default: begin
						count <= dec(count, bcd);
						out_out <= !(count == 16'h0001 && armed);
						if (count == 16'h0001)
							armed <= 1'b0;
					end
					endcase
				end
			end
			// gate edge arms the triggered profiles; set after the reload
			// so an edge in the same cycle as a tick is not lost
			if (gate_in && !gate_q)
				trig <= 1'b1;
			// a low gate parks the periodic profiles high
			if (!gate_in && mode[1])
				out_out <= 1'b1;
			// host side: data bytes
			if (wr_in) begin
				case (rwm)
				bct_pkg::RW_LSB: begin
					cr <= {8'h00, wdata_in}; load_pend <= 1'b1;
				end
				bct_pkg::RW_MSB: begin
					cr <= {wdata_in, 8'h00}; load_pend <= 1'b1;
				end
				default: begin
					wtog <= !wtog;
					if (!wtog)
						wlo <= wdata_in;
					else begin
						cr <= {wdata_in, wlo}; load_pend <= 1'b1;
					end
				end
				endcase
				null_cnt <= 1'b1;
				if (prof == bct_pkg::BCT_TERM)
					out_out <= 1'b0;
			end
			if (rd_in) begin
				if (st_latched)
					st_latched <= 1'b0;
				else if (rwm == bct_pkg::RW_BOTH && !rtog)
					rtog <= 1'b1;
				else begin
					rtog <= 1'b0; latched <= 1'b0;
				end
			end
			// latch requests; a held latch is not overwritten
			if ((rb_count_in || (ctl_wr_in && ctl_in[5:4] == bct_pkg::RW_LATCH))
					&& !latched) begin
				ol <= count; latched <= 1'b1;
			end
			if (rb_status_in && !st_latched) begin
				status <= {out_out, null_cnt, rwm, mode, bcd};
				st_latched <= 1'b1;
			end
			// programming a profile restarts the channel
			if (ctl_wr_in && ctl_in[5:4] != bct_pkg::RW_LATCH) begin
				rwm <= ctl_in[5:4]; mode <= ctl_in[3:1]; bcd <= ctl_in[0];
				wtog <= 1'b0; rtog <= 1'b0; latched <= 1'b0;
				null_cnt <= 1'b1; load_pend <= 1'b0; armed <= 1'b0;
				out_out <= (ctl_in[3:1] != 3'h0);
			end
		end
	end

	//****************************************************
	// checks
	//****************************************************
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	a_profile_load: assert property (ctl_wr_in && ctl_in[5:4] != 2'h0
		|=> mode == $past(ctl_in[3:1]) && bcd == $past(ctl_in[0])
		&& rwm == $past(ctl_in[5:4])) else $error("profile not loaded");
	a_bcd_step: assert property (tick_in && !load_pend && gate_in && !trig
		&& !ctl_wr_in && !wr_in && mode == 3'h0 && bcd
		&& count == 16'h0010 |=> count == 16'h0009)
		else $error("decimal borrow wrong");
	a_lsb_only: assert property (wr_in && rwm == 2'h1 && !ctl_wr_in
		|=> cr == {8'h00, $past(wdata_in)}) else $error("low byte load wrong");
	a_latch_hold: assert property (latched && !rd_in && !ctl_wr_in
		|=> $stable(ol) && latched) else $error("latched count moved");
endmodule

// ==== core/bct_ports.sv ====
// host port window: counter bank and indexed array bank on one offset set
//****************************************************
//****************************************************
`timescale 1ns/10ps
module bct_ports #(
	parameter int ARRAY_DEPTH = 256 // indexed array bytes
) (
	input  wire logic        mclk_in,                 // 40 MHz clock
	input  wire logic        rst_in,                  // synchronous reset
	input  wire logic [3:0]  io_addr_in,              // I/O offset
	input  wire logic        io_wr_in,                // write cycle strobe
	input  wire logic        io_rd_in,                // read cycle strobe
	input  wire logic        io_wide_in,              // 16-bit cycle
	input  wire logic [15:0] io_wdata_in,             // write data
	output logic      [15:0] io_rdata_out,            // read data
	input  wire logic        cfg_wr_in,               // config reg write
	input  wire logic [7:0]  cfg_data_in,             // config reg data
	input  wire logic        increment_inhibit_in,    // stop auto-step
	input  wire logic [2:0]  ct_tick_in,              // counting enables
	input  wire logic [2:0]  ct_gate_in,              // counter gates
	output logic      [2:0]  ct_out_out,              // counter outputs
	output logic             bank_status_out,         // 1: indexed bank
	output logic      [7:0]  index_pointer_value_out  // index pointer
);
	typedef enum {KEY_IDLE, KEY_ON1, KEY_ON2, KEY_OFF1, KEY_OFF2} bct_key_type;

	bct_key_type      key_state, next_key;
	logic [7:0]       ptr, a0, a1, step;
	logic             hit, wide;
	logic [3:0]       nib;
	logic [7:0]       arr [ARRAY_DEPTH];
	logic [2:0][7:0]  ct_rdata;
	logic [2:0][7:0]  ct_wdata;
	logic [2:0]       ct_wr, ct_rd, ct_ctl_wr, rb_cnt, rb_sts;
	logic             cw_hit;
	logic [7:0]       cw;

	assign ptr = index_pointer_value_out;
	assign nib = cfg_data_in[7:4];

	// byte address inside the array carries a counter port
	function automatic logic is_port(input logic [7:0] a);
		return a >= bct_pkg::IDX_CT0 && a <= bct_pkg::IDX_CTRL;
	endfunction

	// byte that a read at array place a returns; control is write only
	function automatic logic [7:0] byte_of(input logic [7:0] a);
		if (a >= bct_pkg::IDX_CT0 && a < bct_pkg::IDX_CTRL)
			return ct_rdata[2'(a - bct_pkg::IDX_CT0)];
		else if (a == bct_pkg::IDX_CTRL)
			return 8'h00;
		else
			return arr[a];
	endfunction

	//****************************************************
	// address decode
	//****************************************************
	// bank zero offsets fold onto the same array places as bank one
	always_comb begin
		hit  = 1'b0;
		a0   = 8'h00;
		wide = 1'b0;
		step = 8'h00;
		if (!bank_status_out) begin
			if (io_addr_in >= bct_pkg::OFS_CT0) begin
				hit = 1'b1;
				a0  = bct_pkg::IDX_CT0 + {4'h0, 4'(io_addr_in - bct_pkg::OFS_CT0)};
			end
		end else if (io_addr_in == bct_pkg::OFS_IDX_LO) begin
			hit  = 1'b1;
			a0   = ptr;
			wide = io_wide_in;
			step = io_wide_in ? 8'h02 : 8'h01;
		end else if (io_addr_in == bct_pkg::OFS_IDX_HI) begin
			hit  = 1'b1;
			a0   = 8'(ptr + 8'h01);
			step = 8'h01;
		end
	end
	assign a1 = 8'(a0 + 8'h01);

	//****************************************************
	// counter port strobes
	//****************************************************
	genvar i;
	generate
		for (i = 0; i < 3; i++) begin : g_ch
			logic lo_me, hi_me;
			assign lo_me = hit && a0 == 8'(bct_pkg::IDX_CT0 + 8'(i));
			assign hi_me = hit && wide && a1 == 8'(bct_pkg::IDX_CT0 + 8'(i));
			assign ct_wr[i] = io_wr_in && (lo_me || hi_me);
			assign ct_rd[i] = io_rd_in && (lo_me || hi_me);
			assign ct_wdata[i] = lo_me ? io_wdata_in[7:0] : io_wdata_in[15:8];
			// read-back picks channels by bits 1..3, latch bits low active
			assign ct_ctl_wr[i] = cw_hit
				&& cw[7:6] == 2'(i) ;
			assign rb_cnt[i] = cw_hit && cw[7:6] == bct_pkg::SC_READBACK
				&& cw[i+1] && !cw[bct_pkg::CW_CNT_BIT];
			assign rb_sts[i] = cw_hit && cw[7:6] == bct_pkg::SC_READBACK
				&& cw[i+1] && !cw[bct_pkg::CW_STS_BIT];
			bct_channel u_ch (
				.mclk_in      (mclk_in),
				.rst_in       (rst_in),
				.ctl_wr_in    (ct_ctl_wr[i]),
				.ctl_in       (cw[5:0]),
				.rb_count_in  (rb_cnt[i]),
				.rb_status_in (rb_sts[i]),
				.wr_in        (ct_wr[i]),
				.rd_in        (ct_rd[i]),
				.wdata_in     (ct_wdata[i]),
				.rdata_out    (ct_rdata[i]),
				.tick_in      (ct_tick_in[i]),
				.gate_in      (ct_gate_in[i]),
				.out_out      (ct_out_out[i])
			);
		end
	endgenerate

	// control word arrives as a byte at place 71, low or high lane
	assign cw_hit = io_wr_in && hit && (a0 == bct_pkg::IDX_CTRL
		|| (wide && a1 == bct_pkg::IDX_CTRL));
	assign cw = (a0 == bct_pkg::IDX_CTRL) ? io_wdata_in[7:0]
		: io_wdata_in[15:8];

	//****************************************************
	// indexed array storage, left unreset as plain memory
	//****************************************************
	always_ff @(posedge mclk_in) begin
		if (io_wr_in && hit) begin
			if (!is_port(a0))
				arr[a0] <= io_wdata_in[7:0];
			if (wide && !is_port(a1))
				arr[a1] <= io_wdata_in[15:8];
		end
	end

	// read data, one cycle after the read strobe
	always_ff @(posedge mclk_in) begin
		if (rst_in)
			io_rdata_out <= 16'h0000;
		else if (io_rd_in && hit)
			io_rdata_out <= {wide ? byte_of(a1) : 8'h00, byte_of(a0)};
		else if (io_rd_in && bank_status_out
				&& io_addr_in == bct_pkg::OFS_IDX_PTR)
			io_rdata_out <= {8'h00, ptr};
	end

	//****************************************************
	// index pointer
	//****************************************************
	always_ff @(posedge mclk_in) begin
		if (rst_in)
			index_pointer_value_out <= bct_pkg::PTR_RESET;
		else if (io_wr_in && bank_status_out
				&& io_addr_in == bct_pkg::OFS_IDX_PTR)
			index_pointer_value_out <= io_wdata_in[7:0];
		else if ((io_wr_in || io_rd_in) && hit && bank_status_out
				&& !increment_inhibit_in)
			index_pointer_value_out <= 8'(ptr + step);
	end

	//****************************************************
	// bank key sequence
	//****************************************************
	// a repeated first nibble restarts, so a doubled first key write still unlocks
	always_comb begin
		next_key = key_state;
		if (cfg_wr_in) begin
			if (nib == bct_pkg::KEY_ON1)
				next_key = KEY_ON1;
			else if (nib == bct_pkg::KEY_OFF1)
				next_key = KEY_OFF1;
			else
				case (key_state)
				KEY_ON1:  next_key = (nib == bct_pkg::KEY_ON2) ? KEY_ON2 : KEY_IDLE;
				KEY_OFF1: next_key = (nib == bct_pkg::KEY_OFF2) ? KEY_OFF2 : KEY_IDLE;
				default:  next_key = KEY_IDLE;
				endcase
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in)
			key_state <= KEY_IDLE;
		else
			key_state <= next_key;
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in)
			bank_status_out <= 1'b0;
		else if (cfg_wr_in && key_state == KEY_ON2 && nib == bct_pkg::KEY_ON3)
			bank_status_out <= 1'b1;
		else if (cfg_wr_in && key_state == KEY_OFF2 && nib == bct_pkg::KEY_OFF3)
			bank_status_out <= 1'b0;
	end

	//****************************************************
	// checks
	//****************************************************
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	sequence s_key_on;
		cfg_wr_in && nib == 4'hf ##1 cfg_wr_in && nib == 4'h5
		##1 cfg_wr_in && nib == 4'hd;
	endsequence
	sequence s_key_off;
		cfg_wr_in && nib == 4'h3 ##1 cfg_wr_in && nib == 4'hb
		##1 cfg_wr_in && nib == 4'ha;
	endsequence

	a_counter_port: assert property (!bank_status_out && io_wr_in
		&& io_addr_in == 4'hd && !io_wide_in |-> ct_wr == 3'b010)
		else $error("counter one port not written");
	a_ctrl_pick: assert property (!bank_status_out && io_wr_in
		&& io_addr_in == 4'hf && io_wdata_in[7:6] == 2'h2
		|-> ct_ctl_wr == 3'b100) else $error("control word misrouted");
	a_readback_cmd: assert property (!bank_status_out && io_wr_in
		&& io_addr_in == 4'hf && io_wdata_in[7:5] == 3'b110
		&& io_wdata_in[1] |-> rb_cnt[0] && ct_ctl_wr == 3'b000)
		else $error("read-back not issued");
	a_index_map: assert property (bank_status_out && io_wr_in
		&& io_addr_in == 4'hc && !io_wide_in && ptr == 8'd70
		|-> ct_wr == 3'b100) else $error("index 70 not counter two");
	a_word_split: assert property (bank_status_out && io_wr_in
		&& io_addr_in == 4'hc && io_wide_in && ptr == 8'd67
		|-> ct_wr[0] && ct_wdata[0] == io_wdata_in[15:8])
		else $error("word high byte lost");
	a_ptr_step: assert property (bank_status_out && io_rd_in && !io_wr_in
		&& io_addr_in == 4'hc && !increment_inhibit_in
		|=> ptr == 8'($past(ptr) + ($past(io_wide_in) ? 8'h02 : 8'h01)))
		else $error("pointer step wrong");
	a_bank_enter: assert property (s_key_on |=> bank_status_out)
		else $error("bank not entered");
	a_bank_leave: assert property (s_key_off |=> !bank_status_out)
		else $error("bank not left");
	a_bank_steady: assert property (!cfg_wr_in |=> $stable(bank_status_out))
		else $error("bank moved without key");
endmodule

// ==== inc/bct_pkg.sv ====
// constants and types shared by the banked counter/timer port window
package bct_pkg;

	//****************************************************
	// host port offsets
	//****************************************************
	localparam logic [3:0] OFS_CT0     = 4'hc; // counter zero data, bank 0
	localparam logic [3:0] OFS_CTRL    = 4'hf; // control word, bank 0
	localparam logic [3:0] OFS_IDX_LO  = 4'hc; // indexed data low/word, bank 1
	localparam logic [3:0] OFS_IDX_HI  = 4'hd; // indexed data high byte, bank 1
	localparam logic [3:0] OFS_IDX_PTR = 4'he; // index pointer, bank 1

	//****************************************************
	// indexed array places of the counter ports
	//****************************************************
	localparam logic [7:0] IDX_CT0   = 8'h44; // 68: counter zero data
	localparam logic [7:0] IDX_CTRL  = 8'h47; // 71: control word
	localparam logic [7:0] PTR_RESET = 8'h00;

	//****************************************************
	// bank key nibbles
	//****************************************************
	localparam logic [3:0] KEY_ON1  = 4'hf;
	localparam logic [3:0] KEY_ON2  = 4'h5;
	localparam logic [3:0] KEY_ON3  = 4'hd;
	localparam logic [3:0] KEY_OFF1 = 4'h3;
	localparam logic [3:0] KEY_OFF2 = 4'hb;
	localparam logic [3:0] KEY_OFF3 = 4'ha;

	//****************************************************
	// control word fields
	//****************************************************
	localparam int         CW_SC_POS   = 6; // counter pick, two bits
	localparam int         CW_RW_POS   = 4; // byte access order, two bits
	localparam int         CW_CNT_BIT  = 5; // read-back: low latches count
	localparam int         CW_STS_BIT  = 4; // read-back: low latches status
	localparam logic [1:0] SC_READBACK = 2'h3;
	localparam logic [1:0] RW_LATCH    = 2'h0;
	localparam logic [1:0] RW_LSB      = 2'h1;
	localparam logic [1:0] RW_MSB      = 2'h2;
	localparam logic [1:0] RW_BOTH     = 2'h3;

	typedef enum {BCT_TERM, BCT_ONESHOT, BCT_RATE, BCT_SQUARE,
		BCT_SWSTROBE, BCT_HWSTROBE} bct_profile_type;

	// operating profile from the three profile bits
	function automatic bct_profile_type profile(input logic [2:0] m);
		if (m[1])
			return m[0] ? BCT_SQUARE : BCT_RATE;
		else if (m[2])
			return m[0] ? BCT_HWSTROBE : BCT_SWSTROBE;
		else
			return m[0] ? BCT_ONESHOT : BCT_TERM;
	endfunction

endpackage

// ==== verification/bct_host_model.sv ====
// host processor model issuing I/O cycles and configuration key writes
`timescale 1ns/10ps
module bct_host_model (
	input  wire logic        mclk_in,      // system clock
	output logic      [3:0]  io_addr_out,  // I/O offset
	output logic             io_wr_out,    // write strobe
	output logic             io_rd_out,    // read strobe
	output logic             io_wide_out,  // 16-bit cycle
	output logic      [15:0] io_wdata_out, // write data
	input  wire logic [15:0] io_rdata_in,  // read data
	output logic             cfg_wr_out,   // config write strobe
	output logic      [7:0]  cfg_data_out  // config data
);
	// idle bus at time zero
	initial begin
		io_addr_out = 4'h0;
		io_wr_out = 1'b0;
		io_rd_out = 1'b0;
		io_wide_out = 1'b0;
		io_wdata_out = 16'h0000;
		cfg_wr_out = 1'b0;
		cfg_data_out = 8'h00;
	end

	//****************************************************
	// bus cycles
	//****************************************************
	// one access; released lines are inverted so stale values never match
	task automatic cycle(input logic wr, input logic rd, input logic [3:0] a,
		input logic [15:0] d, input logic w, output logic [15:0] q);
		@(negedge mclk_in);
		io_addr_out = a;
		io_wide_out = w;
		io_wdata_out = d;
		io_wr_out = wr;
		io_rd_out = rd;
		@(negedge mclk_in);
		q = io_rdata_in;
		io_wr_out = 1'b0;
		io_rd_out = 1'b0;
		io_addr_out = ~a;
		io_wdata_out = ~d;
		io_wide_out = ~w;
	endtask

	// one key nibble write to the configuration register
	task automatic key(input logic [3:0] n);
		@(negedge mclk_in);
		cfg_data_out = {n, 4'h6};
		cfg_wr_out = 1'b1;
		@(negedge mclk_in);
		cfg_wr_out = 1'b0;
		cfg_data_out = ~cfg_data_out;
	endtask

	// three key nibbles on back-to-back writes, strobe held high
	task automatic key3(input logic [3:0] n1, input logic [3:0] n2,
		input logic [3:0] n3);
		@(negedge mclk_in);
		cfg_data_out = {n1, 4'h6};
		cfg_wr_out = 1'b1;
		@(negedge mclk_in);
		cfg_data_out = {n2, 4'h6};
		@(negedge mclk_in);
		cfg_data_out = {n3, 4'h6};
		@(negedge mclk_in);
		cfg_wr_out = 1'b0;
		cfg_data_out = ~cfg_data_out;
	endtask
endmodule

// ==== verification/test_banked_counter_timer_ports.sv ====
// self-checking bench for the banked counter/timer port window
`timescale 1ns/10ps
`define CHK(g, e) \
	begin \
		tests_run++; \
		if ((g) !== (e)) begin \
			err_total++; \
			$display("mismatch at %0t: got %h expected %h", $time, g, e); \
		end \
	end
module test_banked_counter_timer_ports;
	logic        mclk_in;
	logic        rst_in;
	logic [3:0]  io_addr;
	logic        io_wr;
	logic        io_rd;
	logic        io_wide;
	logic [15:0] io_wdata;
	logic [15:0] io_rdata;
	logic        cfg_wr;
	logic [7:0]  cfg_data;
	logic        inhibit;
	logic [2:0]  tick;
	logic [2:0]  gate;
	logic [2:0]  ct_out;
	logic        bank;
	logic [7:0]  ptr;
	int          tests_run;
	int          err_total;

	bct_host_model host (.mclk_in(mclk_in), .io_addr_out(io_addr),
		.io_wr_out(io_wr), .io_rd_out(io_rd), .io_wide_out(io_wide),
		.io_wdata_out(io_wdata), .io_rdata_in(io_rdata),
		.cfg_wr_out(cfg_wr), .cfg_data_out(cfg_data));

	bct_ports DUT (.mclk_in(mclk_in), .rst_in(rst_in), .io_addr_in(io_addr),
		.io_wr_in(io_wr), .io_rd_in(io_rd), .io_wide_in(io_wide),
		.io_wdata_in(io_wdata), .io_rdata_out(io_rdata),
		.cfg_wr_in(cfg_wr), .cfg_data_in(cfg_data),
		.increment_inhibit_in(inhibit), .ct_tick_in(tick),
		.ct_gate_in(gate), .ct_out_out(ct_out), .bank_status_out(bank),
		.index_pointer_value_out(ptr));

	// 40 MHz clock
	initial begin
		mclk_in = 1'b0;
		forever #12.5 mclk_in = ~mclk_in;
	end

	//****************************************************
	// helpers
	//****************************************************
	task automatic wr(input logic [3:0] a, input logic [15:0] d,
		input logic w);
		logic [15:0] q;
		host.cycle(1'b1, 1'b0, a, d, w, q);
	endtask

	task automatic rd(input logic [3:0] a, input logic w,
		output logic [15:0] q);
		host.cycle(1'b0, 1'b1, a, 16'h0000, w, q);
	endtask

	// one counting enable pulse for a channel
	task automatic pulse(input int ch);
		@(negedge mclk_in);
		tick[ch] = 1'b1;
		@(negedge mclk_in);
		tick = 3'h0;
	endtask

	// full key sequence; fixed keys keep the bank stable under stray writes
	task automatic set_bank(input logic b);
		host.key3(b ? 4'hf : 4'h3, b ? 4'h5 : 4'hb, b ? 4'hd : 4'ha);
	endtask

	//****************************************************
	// scenarios
	//****************************************************
	task automatic test_reset();
		`CHK(bank, 1'b0);
		`CHK(ptr, 8'h00);
		`CHK(io_rdata, 16'h0000);
	endtask

	// every channel, binary and decimal, one load tick then one count tick
	task automatic test_counters();
		logic [15:0] q;
		logic [3:0]  a;
		for (int i = 0; i < 6; i++) begin
			a = 4'hc + 4'(i / 2);
			wr(4'hf, {8'h00, 2'(i / 2), 2'h3, 3'h0, 1'(i % 2)}, 1'b0);
			wr(a, 16'h0010, 1'b0);
			wr(a, 16'h0000, 1'b0);
			pulse(i / 2);
			pulse(i / 2);
			wr(4'hf, {8'h00, 2'(i / 2), 6'h00}, 1'b0);
			rd(a, 1'b0, q);
			`CHK(q[7:0], (i % 2) ? 8'h09 : 8'h0f);
			rd(a, 1'b0, q);
			`CHK(q[7:0], 8'h00);
		end
	endtask

	// profile codes 0 to 5, seen through a read-back status latch
	task automatic test_profiles();
		logic [15:0] q;
		for (int m = 0; m < 6; m++) begin
			wr(4'hf, {8'h00, 2'h0, 2'h1, 3'(m), 1'b0}, 1'b0);
			wr(4'hf, 16'h00e2, 1'b0);
			rd(4'hc, 1'b0, q);
			`CHK(q[5:0], {2'h1, 3'(m), 1'b0});
		end
	endtask

	task automatic test_bank_key();
		host.key(4'hf);
		host.key(4'h5);
		host.key(4'h7);
		`CHK(bank, 1'b0);
		set_bank(1'b1);
		`CHK(bank, 1'b1);
		host.key(4'h3);
		host.key(4'hb);
		`CHK(bank, 1'b1);
		host.key(4'ha);
		`CHK(bank, 1'b0);
	endtask

	// word and byte lanes of the indexed port, pointer stepping
	task automatic test_indexed();
		logic [15:0] q;
		set_bank(1'b1);
		wr(4'he, 16'h0010, 1'b0);
		`CHK(ptr, 8'h10);
		wr(4'hc, 16'hbeef, 1'b1);
		`CHK(ptr, 8'h12);
		wr(4'he, 16'h0010, 1'b0);
		rd(4'hc, 1'b0, q);
		`CHK(q[7:0], 8'hef);
		`CHK(ptr, 8'h11);
		wr(4'he, 16'h0010, 1'b0);
		rd(4'hd, 1'b0, q);
		`CHK(q[7:0], 8'hbe);
		wr(4'he, 16'h0010, 1'b0);
		rd(4'hc, 1'b1, q);
		`CHK(q, 16'hbeef);
		`CHK(ptr, 8'h12);
		@(negedge mclk_in);
		inhibit = 1'b1;
		rd(4'hc, 1'b1, q);
		`CHK(ptr, 8'h12);
	endtask

	// counters reached through indexes 68..71, pointer held still
	task automatic test_index_counters();
		logic [15:0] q;
		for (int ch = 0; ch < 3; ch++) begin
			wr(4'he, 16'h0047, 1'b0);
			wr(4'hc, {8'h00, 2'(ch), 6'h30}, 1'b0);
			wr(4'he, 16'h0044 + 16'(ch), 1'b0);
			wr(4'hc, 16'h0005, 1'b0);
			wr(4'hc, 16'h0000, 1'b0);
			pulse(ch);
			pulse(ch);
			wr(4'he, 16'h0047, 1'b0);
			wr(4'hc, {8'h00, 2'(ch), 6'h00}, 1'b0);
			wr(4'he, 16'h0044 + 16'(ch), 1'b0);
			rd(4'hc, 1'b0, q);
			`CHK(q[7:0], 8'h04);
			rd(4'hc, 1'b0, q);
			`CHK(q[7:0], 8'h00);
		end
		@(negedge mclk_in);
		inhibit = 1'b0;
		// a word over indexes 67/68 feeds counter zero its high lane
		wr(4'he, 16'h0047, 1'b0);
		wr(4'hc, 16'h0010, 1'b0);
		wr(4'he, 16'h0043, 1'b0);
		wr(4'hc, 16'h07aa, 1'b1);
		pulse(0);
		wr(4'he, 16'h0043, 1'b0);
		rd(4'hc, 1'b1, q);
		`CHK(q, 16'h07aa);
		`CHK(ptr, 8'h45);
		set_bank(1'b0);
		`CHK(bank, 1'b0);
	endtask

	// gate and output behaviour, plus a read-back count latch
	task automatic test_gate_out();
		logic [15:0] q;
		wr(4'hf, 16'h0074, 1'b0);
		wr(4'hd, 16'h0003, 1'b0);
		wr(4'hd, 16'h0000, 1'b0);
		pulse(1);
		pulse(1);
		`CHK(ct_out[1], 1'b1);
		pulse(1);
		`CHK(ct_out[1], 1'b0);
		@(negedge mclk_in);
		gate = 3'h5;
		@(negedge mclk_in);
		`CHK(ct_out[1], 1'b1);
		wr(4'hf, 16'h00d6, 1'b0);
		rd(4'hd, 1'b0, q);
		`CHK(q[7:0], 8'h01);
		rd(4'hd, 1'b0, q);
		`CHK(q[7:0], 8'h00);
		@(negedge mclk_in);
		gate = 3'h3;
		wr(4'hf, 16'h0092, 1'b0);
		wr(4'he, 16'h0002, 1'b0);
		pulse(2);
		`CHK(ct_out[2], 1'b1);
		@(negedge mclk_in);
		gate = 3'h7;
		pulse(2);
		`CHK(ct_out[2], 1'b0);
		pulse(2);
		pulse(2);
		`CHK(ct_out[2], 1'b1);
	endtask

	task automatic stop_test();
		$display("checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// watchdog at 20000 cycles, far beyond the few hundred cycles the run needs
	initial begin
		#(25 * 20000);
		err_total++;
		stop_test();
	end

	// main sequence
	initial begin
		tests_run = 0;
		err_total = 0;
		rst_in = 1'b1;
		inhibit = 1'b0;
		tick = 3'h0;
		gate = 3'h7;
		repeat (3) @(negedge mclk_in);
		rst_in = 1'b0;
		test_reset();
		test_counters();
		test_profiles();
		test_bank_key();
		test_indexed();
		test_index_counters();
		test_gate_out();
		stop_test();
	end
endmodule
